/* logic/sdc_serial_control.sv */
/*
  Digital control and serial output of a 16-bit sigma-delta converter:
  sample FIFO, output register with word-valid flag, three serial framings,
  trim/calibration sequencing, sleep, and an APB status/control slave.
  Assumes the block clock is the master conversion clock; the control and serial pins arrive
  asynchronously and the filter delivers two's complement samples on clock.
*/
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module sdc_serial_control
  import sdc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int CAL_CYCLES = 256
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WORD_BITS-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [1:0] modeSelect,
  input wire logic sleepN,
  input wire logic polaritySelect,
  input wire logic trimCycleRequest,
  input wire logic offsetGainChoiceA,
  input wire logic offsetGainChoiceB,
  input wire logic chipSelectN,
  input wire logic serialShiftClockIn,
  output logic serialShiftClockOut,
  output logic serialShiftClockOe,
  output logic serialOut,
  output logic serialOutOe,
  output logic wordValidN
);
  localparam int CW = $clog2(CAL_CYCLES + 1);

  initial begin
    if (CAL_CYCLES < 1 || CAL_CYCLES > 4096)
      $error("sdc_serial_control: CAL_CYCLES out of range");
    if (FIFO_DEPTH < 2)
      $error("sdc_serial_control: FIFO_DEPTH too small");
  end

  // ************
  // Pin sampling
  // ************
  logic [8:0] pinSync;
  logic [1:0] modeS;
  logic awake, bipolar, trimS, choiceA, choiceB, csSel, csS, sclkS;

  sdc_sync #(
    .WIDTH(9)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din({modeSelect, sleepN, polaritySelect, trimCycleRequest, offsetGainChoiceA, offsetGainChoiceB,
          !chipSelectN, serialShiftClockIn}),
    .dout(pinSync)
  );
  assign {modeS, awake, bipolar, trimS, choiceA, choiceB, csSel, sclkS} = pinSync;
  // Select synced in true sense: the reset value reads as deselected, no false fall
  assign csS = !csSel;

  logic csPrev, sclkPrev, trimPrev;
  logic csFall, sclkFall, trimRise;
  logic isSelf, isAsync;

  assign csFall = csPrev && !csS;
  assign sclkFall = sclkPrev && !sclkS;
  assign trimRise = trimS && !trimPrev;
  assign isSelf = (modeS == MODE_SELF_CLOCKED);
  assign isAsync = (modeS == MODE_ASYNC_CHAR);

  // *********
  // Functions
  // *********
  function automatic logic [WORD_BITS-1:0] toCode(input logic [WORD_BITS-1:0] s, input logic bp);
    if (bp)
      toCode = {~s[WORD_BITS-1], s[WORD_BITS-2:0]};
    else if (s[WORD_BITS-1])
      toCode = '0;
    else
      toCode = {s[WORD_BITS-2:0], 1'b0};
  endfunction

  // Bit idx of the frame; async bytes go high byte first, LSB first
  function automatic logic frameBit(input logic async, input logic [WORD_BITS-1:0] w, input logic [4:0] idx);
    logic [4:0] pos;
    logic [7:0] b;
    pos = (idx < ASYNC_BYTE_BITS) ? idx : idx - ASYNC_BYTE_BITS;
    b = (idx < ASYNC_BYTE_BITS) ? w[15:8] : w[7:0];
    if (!async)
      frameBit = w[4'(SYNC_FRAME_BITS - 5'h1 - idx)];
    else if (pos == 5'h0)
      frameBit = 1'b0;
    else if (pos <= 5'h8)
      frameBit = b[3'(pos - 5'h1)];
    else
      frameBit = 1'b1;
  endfunction

  // ****************************
  // Trim request and calibration
  // ****************************
  sdc_cal_state_t calState, next_calState;
  logic [2:0] trimCount, next_trimCount;
  logic [CW-1:0] calCount, next_calCount;
  logic [1:0] calKind, next_calKind;
  logic calRun;

  assign calRun = (calState == CAL_RUN);

  always_comb begin
    next_calState = calState;
    next_calCount = calCount;
    next_calKind = calKind;
    next_trimCount = trimS ? ((trimCount == TRIM_HOLD_CYCLES) ? trimCount : trimCount + 3'h1) : 3'h0;
    if (trimRise)
      next_calKind = {choiceB, choiceA};
    case (calState)
      CAL_RUN, CAL_BUSY: begin
        if (trimS && trimCount == TRIM_HOLD_CYCLES)
          next_calState = CAL_HOLD;
        else if (calState == CAL_BUSY) begin
          next_calCount = calCount - 1'b1;
          if (calCount == CW'(1))
            next_calState = CAL_RUN;
        end
      end
      CAL_HOLD: begin
        // Released together across devices, so all restart in step
        if (!trimS) begin
          next_calState = CAL_BUSY;
          next_calCount = CW'(CAL_CYCLES);
        end
      end
      default: next_calState = CAL_RUN;
    endcase
  end

  // *********************
  // FIFO and output word
  // *********************
  logic [WORD_BITS-1:0] headWord, outWord, next_outWord, pendWord, next_pendWord;
  logic headValid, headTake, fifoInReady, loadEnable;
  logic [2:0] loadCount, next_loadCount;
  logic fresh, next_fresh, next_wordValidN;
  logic loadStart, loadFinish, frameDone;

  sdc_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .flush(!calRun),
    .inData(sampleData),
    .inValid(sampleValid && awake),
    .inReady(fifoInReady),
    .outData(headWord),
    .outValid(headValid),
    .outReady(headTake)
  );
  // Filter stalls while asleep or calibrating
  assign sampleReady = fifoInReady && awake && calRun;

  assign loadStart = headValid && loadEnable && awake && calRun && (loadCount == 3'h0);
  assign headTake = loadStart;
  assign loadFinish = (loadCount == 3'h1);

  always_comb begin
    next_pendWord = loadStart ? toCode(headWord, bipolar) : pendWord;
    next_loadCount = loadStart ? LOAD_HOLD_CYCLES : (loadCount != 3'h0 ? loadCount - 3'h1 : 3'h0);
    next_outWord = loadFinish ? pendWord : outWord;
    next_fresh = fresh;
    if (!calRun) begin
      next_fresh = 1'b0;
      next_loadCount = 3'h0;
    end else if (loadFinish)
      next_fresh = 1'b1;
    else if (frameDone || loadStart)
      next_fresh = 1'b0;
    next_wordValidN = !(next_fresh && next_loadCount == 3'h0);
  end

  // ******************
  // Serial transmitter
  // ******************
  sdc_tx_state_t txState, next_txState;
  logic [WORD_BITS-1:0] txWord, next_txWord;
  logic [4:0] txIdx, next_txIdx, frameLen;
  logic [1:0] sclkPhase, next_sclkPhase;
  logic txBit, next_txBit, stepEvt;

  assign frameLen = isAsync ? ASYNC_FRAME_BITS : SYNC_FRAME_BITS;
  // Self mode steps at the end of the high phase, as the clock falls
  assign stepEvt = isSelf ? (sclkPhase == SCLK_HIGH_PHASE) : sclkFall;
  assign frameDone = (txState == TX_SHIFT) && !csS && stepEvt && (txIdx == frameLen - 5'h1);

  always_comb begin
    next_txState = txState;
    next_txWord = txWord;
    next_txIdx = txIdx;
    next_sclkPhase = sclkPhase;
    next_txBit = txBit;
    if (!calRun) begin
      next_txState = TX_IDLE;
      next_txBit = 1'b1;
    end else if (txState == TX_IDLE) begin
      if (csFall && awake) begin
        next_txState = TX_SHIFT;
        next_txWord = outWord;
        next_txIdx = 5'h0;
        next_sclkPhase = SCLK_FIRST_PHASE;
        next_txBit = frameBit(isAsync, outWord, 5'h0);
      end
    end else if (csS) begin
      // Early deselect abandons the frame; the word stays fresh
      next_txState = TX_IDLE;
      next_txBit = 1'b1;
    end else begin
      if (isSelf)
        next_sclkPhase = sclkPhase + 2'h1;
      if (frameDone) begin
        next_txState = TX_IDLE;
        next_txBit = 1'b1;
      end else if (stepEvt) begin
        next_txIdx = txIdx + 5'h1;
        next_txBit = frameBit(isAsync, txWord, txIdx + 5'h1);
      end
    end
  end

  // *********
  // APB slave
  // *********
  logic [31:0] statusWord, next_prdata;
  logic next_loadEnable;

  function automatic logic addrMapped(input logic [7:0] a);
    addrMapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_LAST_WORD);
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrMapped(paddr);

  always_comb begin
    statusWord = '0;
    statusWord[ST_FRESH] = fresh;
    statusWord[ST_LOADING] = (loadCount != 3'h0);
    statusWord[ST_TX_BUSY] = (txState == TX_SHIFT);
    statusWord[ST_CAL_BUSY] = (calState == CAL_BUSY);
    statusWord[ST_CAL_HOLD] = (calState == CAL_HOLD);
    statusWord[ST_CAL_KIND +: 2] = calKind;
    statusWord[ST_ASLEEP] = !awake;
    statusWord[ST_MODE +: 2] = modeS;
    statusWord[ST_BIPOLAR] = bipolar;
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: next_prdata = {31'h0, loadEnable};
        ADDR_STATUS: next_prdata = statusWord;
        ADDR_LAST_WORD: next_prdata = {16'h0, outWord};
        default: next_prdata = '0;
      endcase
    end
    next_loadEnable = loadEnable;
    if (psel && penable && pwrite && paddr == ADDR_CTRL)
      next_loadEnable = pwdata[CTRL_LOAD_EN];
  end

  // *********
  // Registers
  // *********
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
      trimPrev <= 1'b0;
      calState <= CAL_RUN;
      trimCount <= 3'h0;
      calCount <= '0;
      calKind <= 2'h0;
      pendWord <= '0;
      outWord <= '0;
      loadCount <= 3'h0;
      fresh <= 1'b0;
      wordValidN <= 1'b1;
      txState <= TX_IDLE;
      txWord <= '0;
      txIdx <= 5'h0;
      sclkPhase <= 2'h0;
      txBit <= 1'b1;
      serialOut <= 1'b1;
      serialOutOe <= 1'b0;
      serialShiftClockOut <= 1'b0;
      serialShiftClockOe <= 1'b0;
      prdata <= '0;
      loadEnable <= CTRL_LOAD_EN_RESET;
    end else begin
      csPrev <= csS;
      sclkPrev <= sclkS;
      trimPrev <= trimS;
      calState <= next_calState;
      trimCount <= next_trimCount;
      calCount <= next_calCount;
      calKind <= next_calKind;
      pendWord <= next_pendWord;
      outWord <= next_outWord;
      loadCount <= next_loadCount;
      fresh <= next_fresh;
      wordValidN <= next_wordValidN;
      txState <= next_txState;
      txWord <= next_txWord;
      txIdx <= next_txIdx;
      sclkPhase <= next_sclkPhase;
      txBit <= next_txBit;
      serialOut <= next_txBit;
      serialOutOe <= !csS;
      serialShiftClockOut <= (next_txState == TX_SHIFT) && isSelf && (next_sclkPhase == SCLK_HIGH_PHASE);
      serialShiftClockOe <= isSelf;
      prdata <= next_prdata;
      loadEnable <= next_loadEnable;
    end
  end
endmodule

/* logic/sdc_pkg.sv */
/*
  Constants, types and register map of the converter's serial control block.
  Assumes one 100 MHz clock that also serves as the master conversion clock.
*/
package sdc_pkg;

  localparam int WORD_BITS = 16;

  localparam logic [1:0] MODE_ASYNC_CHAR = 2'h0;
  localparam logic [1:0] MODE_EXT_CLOCKED = 2'h1;
  localparam logic [1:0] MODE_SELF_CLOCKED = 2'h2;

  localparam logic [4:0] SYNC_FRAME_BITS = 5'h10;
  localparam logic [4:0] ASYNC_FRAME_BITS = 5'h16;
  localparam logic [4:0] ASYNC_BYTE_BITS = 5'h0b;

  localparam logic [2:0] TRIM_HOLD_CYCLES = 3'h4;
  localparam logic [2:0] LOAD_HOLD_CYCLES = 3'h4;
  localparam logic [1:0] SCLK_HIGH_PHASE = 2'h0;
  localparam logic [1:0] SCLK_FIRST_PHASE = 2'h1;

  // ****************
  // APB register map
  // ****************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LAST_WORD = 8'h08;

  localparam int CTRL_LOAD_EN = 0;
  localparam logic CTRL_LOAD_EN_RESET = 1'b1;

  localparam int ST_FRESH = 0;
  localparam int ST_LOADING = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_CAL_BUSY = 3;
  localparam int ST_CAL_HOLD = 4;
  localparam int ST_CAL_KIND = 5;
  localparam int ST_ASLEEP = 7;
  localparam int ST_MODE = 8;
  localparam int ST_BIPOLAR = 10;

  typedef enum logic {TX_IDLE, TX_SHIFT} sdc_tx_state_t;
  typedef enum logic [1:0] {CAL_RUN, CAL_HOLD, CAL_BUSY} sdc_cal_state_t;

endpackage

/* logic/sdc_sync.sv */
/*
  Two-flop synchroniser for a bundle of independent pin levels.
  Assumes each bit is a slow level or a clock well below half the sampling rate.
*/
`timescale 1ns/1ps
module sdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* logic/sdc_fifo.sv */
/*
  Word FIFO between the filter output and the converter's output register.
  Assumes one clock; the head word comes out of a register.
*/
`timescale 1ns/1ps
module sdc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  import sdc_pkg::*;
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("sdc_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic next_outValid;
  logic push, pop;

  // Head register counts as a slot, so DEPTH words in all
  assign inReady = (count + (AW+1)'(outValid)) < (AW+1)'(DEPTH);
  assign push = inValid && inReady && !flush;
  assign pop = (count != '0) && (!outValid || outReady) && !flush;

  always_comb begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
    next_outValid = pop || (outValid && !outReady);
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
      next_outValid = 1'b0;
    end
  end

  // Storage has no reset, so it maps onto plain RAM
  always_ff @(posedge clock) begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      outValid <= next_outValid;
      if (pop)
        outData <= mem[rdPtr];
    end
  end
endmodule

/* testbench/sdc_serial_control_checker.sv */
/*
  Checker on the converter serial control pins.
  Assumes binding to sdc_serial_control; pins pass a two-flop synchroniser.
*/
`timescale 1ns/1ps
module sdc_serial_control_checker
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [1:0] modeSelect,
  input wire logic sleepN,
  input wire logic trimCycleRequest,
  input wire logic chipSelectN,
  input wire logic sampleReady,
  input wire logic serialShiftClockOut,
  input wire logic serialShiftClockOe,
  input wire logic serialOutOe,
  input wire logic wordValidN
);
  logic [2:0] upCnt;
  logic [4:0] pulseCnt;
  // Pins take a few edges after reset to reach the logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upCnt <= 3'h0;
      pulseCnt <= 5'h00;
    end else begin
      if (upCnt != 3'h7) begin
        upCnt <= upCnt + 3'h1;
      end
      if (chipSelectN) begin
        pulseCnt <= 5'h00;
      end else if (serialShiftClockOut && pulseCnt != 5'h1f) begin
        pulseCnt <= pulseCnt + 5'h01;
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_clock_dir: assert property (upCnt == 3'h7 |-> serialShiftClockOe == (modeSelect == MODE_SELF_CLOCKED))
    else $error("shift clock direction wrong");
  chk_clock_duty: assert property (serialShiftClockOut |-> serialShiftClockOe ##1 !serialShiftClockOut [*3])
    else $error("shift clock high too long");
  chk_clock_period: assert property ($fell(serialShiftClockOut) ##3 (pulseCnt < 5'h10 && !chipSelectN)
    |-> serialShiftClockOut)
    else $error("shift clock period not four");
  chk_frame_len: assert property (pulseCnt <= 5'h10)
    else $error("more than sixteen clocks in a frame");
  chk_data_released: assert property (chipSelectN [*4] |-> !serialOutOe)
    else $error("data driven while deselected");
  chk_data_driven: assert property ((upCnt == 3'h7 && !chipSelectN) [*4] |-> serialOutOe)
    else $error("data not driven while selected");
  chk_load_hold: assert property ($rose(wordValidN) |-> wordValidN [*4])
    else $error("valid flag low within four cycles");
  chk_sent_clears: assert property ($rose(pulseCnt == 5'h10) |-> ##[0:3] wordValidN)
    else $error("valid flag low after frame");
  chk_sleep_stall: assert property (!sleepN [*3] |-> !sampleReady)
    else $error("samples taken while asleep");
  chk_trim_hold: assert property (trimCycleRequest [*8] |=> !sampleReady && wordValidN)
    else $error("no reset under long trim request");
  cover property (serialShiftClockOut);
  cover property ($rose(wordValidN) ##4 !wordValidN);
  cover property ($fell(trimCycleRequest) && !sampleReady);
endmodule

bind sdc_serial_control sdc_serial_control_checker sdc_serial_control_checker_inst (
  .clock, .arst_n, .modeSelect, .sleepN, .trimCycleRequest, .chipSelectN, .sampleReady,
  .serialShiftClockOut, .serialShiftClockOe, .serialOutOe, .wordValidN);

/* testbench/sdc_host_model.sv */
/*
  Host serial port: selects the converter and collects one frame.
  Assumes the testbench resolves the shared shift clock wire.
*/
`timescale 1ns/1ps
module sdc_host_model (
  input wire logic serialShiftClockOut,
  input wire logic serialOut,
  input wire logic serialOutOe,
  output logic chipSelectN,
  output logic hostClock
);
  logic dataLine;
  // Released line reads inverted so a stray sample shows up
  assign dataLine = serialOutOe ? serialOut : !serialOut;
  initial begin
    chipSelectN = 1'b1;
    hostClock = 1'b0;
  end
  // Host clock runs only inside a frame, 125 ns period
  task automatic frame(input int nBits, input bit selfClk, output logic [21:0] bits);
    bits = '0;
    chipSelectN = 1'b0;
    if (!selfClk) begin
      #500;
    end
    for (int i = 0; i < nBits; i++) begin
      if (selfClk) begin
        @(posedge serialShiftClockOut);
      end else begin
        hostClock = 1'b1;
      end
      bits = {bits[20:0], dataLine};
      if (!selfClk) begin
        #62.5 hostClock = 1'b0;
        #62.5;
      end
    end
    #200 chipSelectN = 1'b1;
    #500;
  endtask
endmodule

/* testbench/testbench.sv */
/*
  Self-checking bench for the converter serial control block.
  Assumes the host model on the serial pins and an APB master here.
*/
`timescale 1ns/1ps
module testbench
  import sdc_pkg::*;
;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sampleData;
  logic sampleValid, sampleReady, sleepN, polaritySelect, trimCycleRequest;
  logic offsetGainChoiceA, offsetGainChoiceB, chipSelectN, hostClock;
  logic serialShiftClockIn, serialShiftClockOut, serialShiftClockOe, serialOut, serialOutOe, wordValidN;
  logic [1:0] modeSelect;
  logic [21:0] bits;
  logic [15:0] sIn [4] = '{16'h1234, 16'h1234, 16'hf000, 16'h8000};
  logic [15:0] sOut [4] = '{16'h9234, 16'h2468, 16'h0000, 16'h0000};
  logic [3:0] polBits = 4'b1001;
  int fails, checks, n;

  sdc_serial_control #(.FIFO_DEPTH(32), .CAL_CYCLES(16)) sdc_serial_control_inst (.clock, .arst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleData, .sampleValid,
    .sampleReady, .modeSelect, .sleepN, .polaritySelect, .trimCycleRequest, .offsetGainChoiceA,
    .offsetGainChoiceB, .chipSelectN, .serialShiftClockIn, .serialShiftClockOut, .serialShiftClockOe,
    .serialOut, .serialOutOe, .wordValidN);
  sdc_host_model sdc_host_model_inst (.serialShiftClockOut, .serialOut, .serialOutOe, .chipSelectN, .hostClock);
  assign serialShiftClockIn = serialShiftClockOe ? serialShiftClockOut : hostClock;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #500000;
    fails++;
    finish_test();
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart(input logic [1:0] m);
    @(posedge clock);
    arst_n <= 1'b0;
    modeSelect <= m;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic push(input logic [15:0] s);
    @(posedge clock);
    sampleData <= s;
    sampleValid <= 1'b1;
    @(posedge clock);
    while (sampleReady !== 1'b1) @(posedge clock);
    sampleValid <= 1'b0;
  endtask
  task automatic wait_fresh;
    int k;
    k = 0;
    while (wordValidN !== 1'b0 && k < 100) begin
      @(posedge clock);
      k++;
    end
    check("wordValidN fresh", 32'h0, wordValidN);
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7 - i];
    end
  endfunction
  task automatic xfer(input logic [1:0] m, input logic [15:0] w);
    logic [21:0] exp;
    exp = {6'h00, w};
    if (m == MODE_ASYNC_CHAR) begin
      exp = {1'b0, rev8(w[15:8]), 2'h3, 1'b0, rev8(w[7:0]), 2'h3};
    end
    check("data released", 32'h0, serialOutOe);
    check("clock direction", 32'(m == MODE_SELF_CLOCKED), serialShiftClockOe);
    sdc_host_model_inst.frame(m == MODE_ASYNC_CHAR ? 22 : 16, m == MODE_SELF_CLOCKED, bits);
    check("serial frame", exp, bits);
    repeat (4) @(posedge clock);
    check("wordValidN sent", 32'h1, wordValidN);
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sampleData = 16'h0000;
    sampleValid = 1'b0;
    modeSelect = MODE_EXT_CLOCKED;
    sleepN = 1'b1;
    polaritySelect = 1'b1;
    trimCycleRequest = 1'b0;
    offsetGainChoiceA = 1'b0;
    offsetGainChoiceB = 1'b0;
    restart(MODE_EXT_CLOCKED);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", 32'h1, rd);
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status mode", {polaritySelect, MODE_EXT_CLOCKED}, rd[10:8]);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped error", 32'h1, err);
    check("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      polaritySelect <= polBits[i];
      repeat (4) @(posedge clock);
      push(sIn[i]);
      wait_fresh();
      xfer(MODE_EXT_CLOCKED, sOut[i]);
    end
    $display("test polarity done");
    for (int m = 0; m < 3; m += 2) begin
      restart(m[1:0]);
      push(16'h5a3c);
      wait_fresh();
      xfer(m[1:0], 16'hda3c);
    end
    push(16'h0042);
    wait_fresh();
    fork
      sdc_host_model_inst.frame(16, 1'b1, bits);
      begin
        repeat (20) @(posedge clock);
        push(16'h0100);
      end
    join
    check("frame during load", 32'h8042, bits);
    apb(1'b0, ADDR_LAST_WORD, 32'h0);
    check("word loaded mid frame", 32'h8100, rd);
    $display("test modes done");
    restart(MODE_EXT_CLOCKED);
    apb(1'b1, ADDR_CTRL, 32'h0);
    n = 0;
    sampleValid <= 1'b1;
    sampleData <= 16'h0000;
    repeat (40) begin
      @(posedge clock);
      if (sampleReady === 1'b1) begin
        n++;
        sampleData <= n[15:0];
      end
    end
    sampleValid <= 1'b0;
    check("fifo depth", 32'h20, n);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (400) @(posedge clock);
    apb(1'b0, ADDR_LAST_WORD, 32'h0);
    check("drained word", 32'h801f, rd);
    check("wordValidN drained", 32'h0, wordValidN);
    $display("test fifo done");
    offsetGainChoiceA <= 1'b1;
    offsetGainChoiceB <= 1'b0;
    @(posedge clock);
    trimCycleRequest <= 1'b1;
    repeat (4) @(posedge clock);
    trimCycleRequest <= 1'b0;
    repeat (6) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("short trim", 32'h0, rd[4:3]);
    trimCycleRequest <= 1'b1;
    repeat (10) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("trim hold", 32'h1, rd[ST_CAL_HOLD]);
    check("cal kind", 32'h1, rd[6:5]);
    check("wordValidN trim", 32'h1, wordValidN);
    trimCycleRequest <= 1'b0;
    repeat (3) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("cal busy", 32'h1, rd[ST_CAL_BUSY]);
    repeat (40) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("cal over", 32'h0, rd[4:3]);
    $display("test trim done");
    sleepN <= 1'b0;
    repeat (4) @(posedge clock);
    check("ready asleep", 32'h0, sampleReady);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("asleep flag", 32'h1, rd[ST_ASLEEP]);
    sleepN <= 1'b1;
    $display("test sleep done");
    finish_test();
  end
endmodule
